/* pin_partner.sv */
// far side: receiver sensing the audio pin, and the mute switch
`timescale 1ns/1ps
module pin_partner (
   input  wire clk,
   input  wire oe,
   input  wire o,
   input  wire pd,
   input  wire mute_on,
   output wire level,
   output reg  mute_n
);
   reg last_q = 1'b0;
   // released wire: pull-down wins, else show inverse of last drive
   assign level = oe ? o : (pd ? 1'b0 : ~last_q);
   initial mute_n = 1'b1;
   always @(posedge clk) begin
      if (oe)
         last_q <= o;
      mute_n <= ~mute_on;
   end
endmodule // pin_partner

/* pinsel_defines.vh */
// constants for the shared pin function select block
`ifndef PINSEL_DEFINES_VH
`define PINSEL_DEFINES_VH

// register byte addresses
`define REG_GPIO_EN      8'h00
`define REG_PORT_CFG     8'h04
`define REG_GPIO_OUT     8'h08
`define REG_STATUS       8'h0C

// field positions in io enable register
`define GPIO_EN_AUDIO    0
`define GPIO_EN_MIC1     1
`define GPIO_EN_MIC2     2
// field positions in port configuration register
`define PORT_AUDIO_OUT   0
`define PORT_MIC_IN      1
`define PORT_MIC_GPIO    2

// reset values
`define RST_GPIO_EN      3'h0
`define RST_PORT_CFG     3'h0
`define RST_GPIO_OUT     3'h0

// pin function codes reported in status
`define FN_PULLDOWN      2'h0
`define FN_GPIO          2'h1
`define FN_PRIMARY       2'h2
`define FN_MUTED         2'h3

// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`endif

/* pinsel_props.sv */
// concurrent checks on the shared pin select block ports
`timescale 1ns/1ps
module pinsel_props (
   input wire        clk,
   input wire        resetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_bvalid,
   input wire        mic_mute_n_pin,
   input wire        record_sample_valid,
   input wire [23:0] record_sample,
   input wire        shared_io_audio_out_pin_oe,
   input wire        shared_io_audio_out_pulldown,
   input wire        mic_clock_shared_pin_oe,
   input wire        mic_capture_enable,
   input wire        record_out_valid,
   input wire [23:0] record_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_idle; !shared_io_audio_out_pin_oe |-> shared_io_audio_out_pulldown; endproperty
   a_idle: assert property (p_idle) else $error("audio pin floats");
   property p_cap_clk; mic_capture_enable |-> mic_clock_shared_pin_oe; endproperty
   a_cap_clk: assert property (p_cap_clk) else $error("no mic clock");
   property p_mute; !mic_mute_n_pin [*4] |=> record_out == 24'h000000; endproperty
   a_mute: assert property (p_mute) else $error("sound while muted");
   property p_bypass; record_out != 24'h000000 |-> $past(mic_mute_n_pin, 3); endproperty
   a_bypass: assert property (p_bypass) else $error("mute overridden");
   property p_valid; record_sample_valid |=> record_out_valid; endproperty
   a_valid: assert property (p_valid) else $error("stream dropped");
   property p_data; record_out != 24'h000000 |-> record_out == $past(record_sample); endproperty
   a_data: assert property (p_data) else $error("wrong sample");
   property p_off; !mic_capture_enable [*2] |=> record_out == 24'h000000; endproperty
   a_off: assert property (p_off) else $error("path not muted");
   property p_wr_ans; s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("no write answer");
endmodule // pinsel_props
bind shared_pin_function_select pinsel_props pinsel_props_inst (.*);

/* shared_pin_function_select.v */
// shared pin function select with microphone mute, axi4-lite registers
//
// Chosen here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "pinsel_defines.vh"
module shared_pin_function_select (
   input  wire        clk,
   input  wire        resetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        audio_serial_in,
   input  wire        mic_clock_in,
   input  wire        mic_mute_n_pin,
   input  wire        record_sample_valid,
   input  wire [23:0] record_sample,
   output reg         shared_io_audio_out_pin_o,
   output reg         shared_io_audio_out_pin_oe,
   output reg         shared_io_audio_out_pulldown,
   output reg         mic_clock_shared_pin_o,
   output reg         mic_clock_shared_pin_oe,
   output reg         mic_clock_shared_pulldown,
   output reg         mic_data_shared_pulldown,
   output reg         mic_capture_enable,
   output reg         record_out_valid,
   output reg  [23:0] record_out
);

   // ****************************************************************
   // registers
   // ****************************************************************
   reg [2:0] gpio_en_q;
   reg [2:0] port_cfg_q;
   reg [2:0] gpio_out_q;
   reg [7:0] awaddr_q;
   reg       aw_have_q;
   reg [31:0] wdata_q;
   reg [3:0] wstrb_q;
   reg       w_have_q;
   wire      mute_n_sync;

   // ****************************************************************
   // mute pin synchroniser
   // ****************************************************************
   sync2 u_mute_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (mic_mute_n_pin),
      .q      (mute_n_sync)
   );

   // ****************************************************************
   // pin function decode
   // ****************************************************************
   // precedence order: io enable, then port direction, else pull-down
   function [1:0] audio_fn;
      input [2:0] en;
      input [2:0] cfg;
      begin
         if (en[`GPIO_EN_AUDIO])
            audio_fn = `FN_GPIO;
         else if (cfg[`PORT_AUDIO_OUT])
            audio_fn = `FN_PRIMARY;
         else
            audio_fn = `FN_PULLDOWN;
      end
   endfunction

   // decides which addresses exist for writes; reads decode the address in their own case
   function reg_mapped;
      input [7:0] addr;
      begin
         reg_mapped = (addr == `REG_GPIO_EN) ||
                      (addr == `REG_PORT_CFG) ||
                      (addr == `REG_GPIO_OUT) ||
                      (addr == `REG_STATUS);
      end
   endfunction

   // status word packing: mute, capture, mic function, audio function
   function [31:0] status_word;
      input       mute_on;
      input       capture;
      input [1:0] mic_fn;
      input [1:0] aud_fn;
      begin
         status_word = {26'h0000000, mute_on, capture, mic_fn, aud_fn};
      end
   endfunction

   reg [1:0] audio_fn_d;
   reg [1:0] mic_fn_d;
   reg       mic_capture_d;
   always @* begin
      audio_fn_d = audio_fn(gpio_en_q, port_cfg_q);
      if (gpio_en_q[`GPIO_EN_MIC1])
         // mute both mic pins, clock and data pulled down
         mic_fn_d = `FN_MUTED;
      else if (gpio_en_q[`GPIO_EN_MIC2])
         mic_fn_d = `FN_GPIO;
      else if (port_cfg_q[`PORT_MIC_IN] && !port_cfg_q[`PORT_MIC_GPIO])
         mic_fn_d = `FN_PRIMARY;
      else
         mic_fn_d = `FN_PULLDOWN;
      // mute path unless mic function decodes to primary
      mic_capture_d = (mic_fn_d == `FN_PRIMARY);
   end

   // ****************************************************************
   // audio output pin
   // ****************************************************************
   // pull-down and drive are exclusive, so the pin never floats
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         shared_io_audio_out_pin_o    <= 1'b0;
         shared_io_audio_out_pin_oe   <= 1'b0;
         shared_io_audio_out_pulldown <= 1'b1;
      end else begin
         shared_io_audio_out_pin_o <= (audio_fn_d == `FN_GPIO) ?
                                      gpio_out_q[`GPIO_EN_AUDIO] :
                                      (audio_fn_d == `FN_PRIMARY) & audio_serial_in;
         shared_io_audio_out_pin_oe   <= (audio_fn_d != `FN_PULLDOWN);
         shared_io_audio_out_pulldown <= (audio_fn_d == `FN_PULLDOWN);
      end
   end

   // ****************************************************************
   // microphone clock pin
   // ****************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mic_clock_shared_pin_o    <= 1'b0;
         mic_clock_shared_pin_oe   <= 1'b0;
         mic_clock_shared_pulldown <= 1'b1;
      end else begin
         mic_clock_shared_pin_o    <= (mic_fn_d == `FN_PRIMARY) & mic_clock_in;
         mic_clock_shared_pin_oe   <= (mic_fn_d == `FN_PRIMARY);
         mic_clock_shared_pulldown <= (mic_fn_d != `FN_PRIMARY);
      end
   end

   // ****************************************************************
   // microphone data pin and capture enable
   // ****************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         mic_data_shared_pulldown <= 1'b1;
         mic_capture_enable       <= 1'b0;
      end else begin
         // data pin is an input; pulled down unless mics are in use
         mic_data_shared_pulldown <= (mic_fn_d != `FN_PRIMARY);
         mic_capture_enable       <= mic_capture_d;
      end
   end

   // ****************************************************************
   // record stream mute
   // ****************************************************************
   // sits after software gain and mute, so no register can undo it
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         record_out_valid <= 1'b0;
         record_out       <= 24'h000000;
      end else begin
         record_out_valid <= record_sample_valid;
         // forced silence, no software path
         // registered enable: stream gating follows the reported capture state one cycle later
         record_out <= (!mute_n_sync || !mic_capture_enable) ? 24'h000000 : record_sample;
      end
   end

   // ****************************************************************
   // axi4-lite write
   // ****************************************************************
   wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
   wire wr_ok = reg_mapped(awaddr_q);
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         awaddr_q      <= 8'h00;
         wdata_q       <= 32'h00000000;
         wstrb_q       <= 4'h0;
         gpio_en_q     <= `RST_GPIO_EN;
         port_cfg_q    <= `RST_PORT_CFG;
         gpio_out_q    <= `RST_GPIO_OUT;
      end else begin
         s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
            if (wstrb_q[0]) begin
               case (awaddr_q)
                  `REG_GPIO_EN:  gpio_en_q  <= wdata_q[2:0];
                  `REG_PORT_CFG: port_cfg_q <= wdata_q[2:0];
                  `REG_GPIO_OUT: gpio_out_q <= wdata_q[2:0];
                  default: begin
                  end
               endcase
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // axi4-lite read
   // ****************************************************************
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `RESP_OKAY;
            case (s_axi_araddr)
               `REG_GPIO_EN:  s_axi_rdata <= {29'h00000000, gpio_en_q};
               `REG_PORT_CFG: s_axi_rdata <= {29'h00000000, port_cfg_q};
               `REG_GPIO_OUT: s_axi_rdata <= {29'h00000000, gpio_out_q};
               `REG_STATUS:   s_axi_rdata <= status_word(!mute_n_sync, mic_capture_d,
                                                         mic_fn_d, audio_fn_d);
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule // shared_pin_function_select

/* shared_pin_function_select_tb.sv */
// self-checking bench for the shared pin select block
`timescale 1ns/1ps
`include "pinsel_defines.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module shared_pin_function_select_tb;
   reg clk = 1'b0, resetn = 1'b0, audio_serial_in = 1'b0, mic_clock_in = 1'b0, mute_on = 1'b0;
   reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, record_sample_valid = 1'b0;
   reg s_axi_bready = 1'b1, s_axi_rready = 1'b1;
   reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg [23:0] record_sample = 24'h0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mic_mute_n_pin;
   wire shared_io_audio_out_pin_o, shared_io_audio_out_pin_oe, shared_io_audio_out_pulldown;
   wire mic_clock_shared_pin_o, mic_clock_shared_pin_oe, mic_clock_shared_pulldown, level;
   wire mic_data_shared_pulldown, mic_capture_enable, record_out_valid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [23:0] record_out;
   integer mismatches = 0, num_checks = 0, cycles = 0;
   shared_pin_function_select shared_pin_function_select_inst (.*);
   pin_partner pin_partner_inst (.clk(clk), .oe(shared_io_audio_out_pin_oe),
      .o(shared_io_audio_out_pin_o), .pd(shared_io_audio_out_pulldown), .mute_on(mute_on),
      .level(level), .mute_n(mic_mute_n_pin));
   always #2.5 clk = ~clk;
   always @(posedge clk) begin
      mic_clock_in <= ~mic_clock_in;
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         mismatches++;
         summarize;
      end
   end
   task summarize;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task look;
      repeat (3) @(negedge clk);
   endtask
   task wr(input [7:0] a, input [31:0] d, input [1:0] r = `RESP_OKAY);
      reg pa, pw;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      pa = 1'b1;
      pw = 1'b1;
      while (pa || pw) begin
         @(posedge clk);
         if (pa && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (pw && s_axi_wready) s_axi_wvalid <= 1'b0;
         pa = pa && !s_axi_awready;
         pw = pw && !s_axi_wready;
      end
      // bready stays high, so the first bvalid seen is the answer
      while (!s_axi_bvalid) @(posedge clk);
      `CHK(s_axi_bresp, r)
   endtask
   task rd(input [7:0] a, input [31:0] e, input [1:0] r = `RESP_OKAY);
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      @(posedge clk);
      while (!s_axi_arready) @(posedge clk);
      s_axi_arvalid <= 1'b0;
      @(posedge clk);
      while (!s_axi_rvalid) @(posedge clk);
      `CHK(s_axi_rdata, e)
      `CHK(s_axi_rresp, r)
   endtask
   task send(input [23:0] d, input [23:0] e);
      @(posedge clk);
      record_sample <= d;
      record_sample_valid <= 1'b1;
      @(posedge clk);
      record_sample_valid <= 1'b0;
      @(negedge clk);
      `CHK(record_out_valid, 1'b1)
      `CHK(record_out, e)
   endtask
   task t_reset;
      @(negedge clk);
      `CHK(level, 1'b0)
      `CHK({mic_clock_shared_pulldown, mic_data_shared_pulldown}, 2'h3)
      look;
      rd(`REG_STATUS, 32'h0);
   endtask
   task t_regs;
      wr(`REG_GPIO_EN, 32'hFFFFFFFF);
      rd(`REG_GPIO_EN, 32'h7);
      rd(`REG_STATUS, 32'hD);
      wr(8'h10, 32'h1, `RESP_SLVERR);
      rd(8'h10, 32'h0, `RESP_SLVERR);
      wr(`REG_GPIO_EN, 32'h0);
   endtask
   task t_audio;
      wr(`REG_PORT_CFG, 32'h1);
      audio_serial_in <= 1'b1;
      look;
      `CHK(level, 1'b1)
      rd(`REG_STATUS, 32'h2);
      wr(`REG_GPIO_EN, 32'h1);
      look;
      `CHK(level, 1'b0)
      rd(`REG_STATUS, 32'h1);
      wr(`REG_GPIO_OUT, 32'h1);
      look;
      `CHK(level, 1'b1)
      wr(`REG_GPIO_OUT, 32'h0);
   endtask
   task t_mic;
      wr(`REG_GPIO_EN, 32'h4);
      wr(`REG_PORT_CFG, 32'h2);
      rd(`REG_STATUS, 32'h4);
      `CHK(shared_io_audio_out_pulldown, 1'b1)
      wr(`REG_GPIO_EN, 32'h2);
      look;
      `CHK({mic_capture_enable, mic_data_shared_pulldown}, 2'h1)
      wr(`REG_PORT_CFG, 32'h6);
      wr(`REG_GPIO_EN, 32'h0);
      look;
      `CHK(mic_capture_enable, 1'b0)
      wr(`REG_PORT_CFG, 32'h2);
      look;
      `CHK({mic_capture_enable, mic_clock_shared_pin_oe}, 2'h3)
   endtask
   task t_mute;
      send(24'hA5A5A5, 24'hA5A5A5);
      @(posedge clk) mute_on <= 1'b1;
      repeat (2) look;
      send(24'h123456, 24'h0);
      rd(`REG_STATUS, 32'h38);
      wr(`REG_PORT_CFG, 32'h2);
      send(24'hFFFFFF, 24'h0);
      @(posedge clk) mute_on <= 1'b0;
      repeat (2) look;
      send(24'h0F0F0F, 24'h0F0F0F);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_regs;
      t_audio;
      t_mic;
      t_mute;
      summarize;
   end
endmodule // shared_pin_function_select_tb

/* sync2.v */
// two flip-flop synchroniser for a single level
`timescale 1ns/1ps
module sync2 (
   input  wire clk,
   input  wire resetn,
   input  wire d,
   output wire q
);
   reg meta_q;
   reg sync_q;
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end
   assign q = sync_q;
endmodule // sync2
